/* File: common/pps_consts.svh */
// Purpose: Constants for the remappable pin output select block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Included by the package and by every design file
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

`define RPS_NUM_PINS        13
`define RPS_CODE_W          5
`define RPS_SLOT_W          4
`define RPS_IDX_W           12
`define RPS_ADDR_W          16
`define RPS_DATA_W          32
`define RPS_PERIPH_W        32

`define RPS_IDX_PIN3        12'hEC9
`define RPS_IDX_PIN4        12'hECA
`define RPS_IDX_PIN5        12'hECB
`define RPS_IDX_PIN6        12'hECC
`define RPS_IDX_PIN7        12'hECD
`define RPS_IDX_PIN8        12'hECE
`define RPS_IDX_PIN9        12'hECF
`define RPS_IDX_PIN10       12'hED0
`define RPS_IDX_PIN11       12'hED1
`define RPS_IDX_PIN12       12'hED2
`define RPS_IDX_PIN13       12'hED3
`define RPS_IDX_PIN17       12'hED7
`define RPS_IDX_PIN18       12'hED8

`define RPS_SLOT_PIN3       4'h0
`define RPS_SLOT_PIN4       4'h1
`define RPS_SLOT_PIN5       4'h2
`define RPS_SLOT_PIN6       4'h3
`define RPS_SLOT_PIN7       4'h4
`define RPS_SLOT_PIN8       4'h5
`define RPS_SLOT_PIN9       4'h6
`define RPS_SLOT_PIN10      4'h7
`define RPS_SLOT_PIN11      4'h8
`define RPS_SLOT_PIN12      4'h9
`define RPS_SLOT_PIN13      4'hA
`define RPS_SLOT_PIN17      4'hB
`define RPS_SLOT_PIN18      4'hC

`define RPS_CODE_LSB        0
`define RPS_CODE_MSB        4
`define RPS_CODE_RESET      5'h00
`define RPS_CODE_NONE       5'h00
`define RPS_ASSIGNED_CODES  32'hFFFF_FFFE

`endif

/* File: common/pps_pkg.sv */
// Purpose: Types shared by the pin output select block and its code bank
// Assumes: Constants come from the guarded header
// Notes:   Every user writes pps_pkg::name; nothing is imported
package pps_pkg;
`include "pps_consts.svh"

	typedef logic [`RPS_CODE_W-1:0] code_t;
	typedef logic [`RPS_SLOT_W-1:0] slot_t;

	typedef struct packed
	{
		logic  hit;
		slot_t slot;
	} slot_dec_t;

	typedef struct packed
	{
		logic  en;
		slot_t slot;
		code_t code;
	} code_wr_t;

	typedef struct packed
	{
		logic  en;
		logic  hit;
		slot_t slot;
	} code_rd_t;

	typedef struct packed
	{
		code_t [`RPS_NUM_PINS-1:0] codes;
		code_t                     rd_data;
	} bank_state_t;

	typedef struct packed
	{
		logic                      ready;
		logic                      slverr;
		logic [`RPS_NUM_PINS-1:0]  pin_en;
		logic [`RPS_NUM_PINS-1:0]  pin_out;
	} sel_state_t;
endpackage

/* File: logic/func_select_bank.sv */
// Purpose: Bank of function codes, one per remappable pin
// Assumes: Writer only raises the write enable for a valid slot
// Notes:   Read data is registered; all codes are also presented in parallel
`include "pps_consts.svh"

module func_select_bank (
	input  wire logic                                i_clk_sys,
	input  wire logic                                i_reset_n,
	input  wire pps_pkg::code_wr_t                   i_wr,
	input  wire pps_pkg::code_rd_t                   i_rd,
	output pps_pkg::code_t                           o_rd_data,
	output pps_pkg::code_t [`RPS_NUM_PINS-1:0]       o_codes
);
	pps_pkg::bank_state_t st_q;
	pps_pkg::bank_state_t st_d;

	always_comb
	begin
		st_d = st_q;
		if (i_wr.en)
		begin
			st_d.codes[i_wr.slot] = i_wr.code;
		end
		if (i_rd.en)
		begin
			// Unmapped reads load zero rather than an out-of-range entry
			st_d.rd_data = i_rd.hit ? st_q.codes[i_rd.slot] : `RPS_CODE_RESET;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign o_rd_data = st_q.rd_data;
	assign o_codes   = st_q.codes;

	reset_clear_a: assert property (@(posedge i_clk_sys)
		$rose(i_reset_n) |-> (st_q.codes == '0))
		else $error("code bank not cleared by reset");
endmodule

/* File: logic/remappable_pin_output_select.sv */
// Purpose: APB register bank choosing which peripheral output drives each remappable pin
// Assumes: Lock and peripheral outputs come from logic on the system clock
// Notes:   Pin outputs are registered, so they follow a code or source change one cycle late
// Behaviour
// - Pin output follows function chosen by code
// - Bits seven to five read zero, ignore writes
// - Codes writable only while lock is clear
// - All codes are zero after reset
// - One register per pin, base plus pin
`include "pps_consts.svh"

module remappable_pin_output_select (
	input  wire logic                          i_clk_sys,
	input  wire logic                          i_reset_n,
	input  wire logic                          i_psel,
	input  wire logic                          i_penable,
	input  wire logic                          i_pwrite,
	input  wire logic [`RPS_ADDR_W-1:0]        i_paddr,
	input  wire logic [`RPS_DATA_W-1:0]        i_pwdata,
	output logic      [`RPS_DATA_W-1:0]        o_prdata,
	output logic                               o_pready,
	output logic                               o_pslverr,
	input  wire logic                          i_pin_config_lock,
	input  wire logic [`RPS_PERIPH_W-1:0]      i_periph_out,
	output logic      [`RPS_NUM_PINS-1:0]      o_pin_out,
	output logic      [`RPS_NUM_PINS-1:0]      o_pin_periph_en
);
	localparam logic [`RPS_PERIPH_W-1:0] assigned_codes = `RPS_ASSIGNED_CODES;

	pps_pkg::sel_state_t                      st_q;
	pps_pkg::sel_state_t                      st_d;
	pps_pkg::slot_dec_t                       dec;
	pps_pkg::code_wr_t                        wr;
	pps_pkg::code_rd_t                        rd;
	pps_pkg::code_t                           rd_code;
	pps_pkg::code_t [`RPS_NUM_PINS-1:0]       codes;
	logic           [`RPS_NUM_PINS-1:0]       route_en;
	logic           [`RPS_NUM_PINS-1:0]       route_val;
	logic                                     setup;
	logic                                     access_done;

	// Word index to pin slot; a misaligned or out-of-window address misses
	function automatic pps_pkg::slot_dec_t decode_index(
		input logic [`RPS_ADDR_W-1:0] addr
	);
		logic [`RPS_IDX_W-1:0] idx;
		pps_pkg::slot_dec_t    r;
		idx    = addr[13:2];
		r.hit  = 1'b0;
		r.slot = '0;
		if (addr[15:14] != 2'h0 || addr[1:0] != 2'h0)
		begin
			r.hit = 1'b0;
		end
		else if (idx == `RPS_IDX_PIN3)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN3;
		end
		else if (idx == `RPS_IDX_PIN4)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN4;
		end
		else if (idx == `RPS_IDX_PIN5)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN5;
		end
		else if (idx == `RPS_IDX_PIN6)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN6;
		end
		else if (idx == `RPS_IDX_PIN7)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN7;
		end
		else if (idx == `RPS_IDX_PIN8)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN8;
		end
		else if (idx == `RPS_IDX_PIN9)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN9;
		end
		else if (idx == `RPS_IDX_PIN10)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN10;
		end
		else if (idx == `RPS_IDX_PIN11)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN11;
		end
		else if (idx == `RPS_IDX_PIN12)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN12;
		end
		else if (idx == `RPS_IDX_PIN13)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN13;
		end
		else if (idx == `RPS_IDX_PIN17)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN17;
		end
		else if (idx == `RPS_IDX_PIN18)
		begin
			r.hit  = 1'b1;
			r.slot = `RPS_SLOT_PIN18;
		end
		return r;
	endfunction

	assign setup       = i_psel && !i_penable;
	assign access_done = i_psel && i_penable && st_q.ready;
	assign dec         = decode_index(i_paddr);

	// Locked writes complete normally on the bus but change nothing
	always_comb
	begin
		wr.en   = access_done && i_pwrite && dec.hit && !i_pin_config_lock;
		wr.slot = dec.slot;
		wr.code = i_pwdata[`RPS_CODE_MSB:`RPS_CODE_LSB];
	end

	// Read is captured at the setup edge so data is ready in the first access cycle
	always_comb
	begin
		rd.en   = setup && !i_pwrite;
		rd.hit  = dec.hit;
		rd.slot = dec.slot;
	end

	func_select_bank u_bank (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_wr      (wr),
		.i_rd      (rd),
		.o_rd_data (rd_code),
		.o_codes   (codes)
	);

	// A code without a function in this part must not steal the pin from the port
	for (genvar p = 0; p < `RPS_NUM_PINS; p++)
	begin : g_pin
		assign route_en[p]  = (codes[p] != `RPS_CODE_NONE) && assigned_codes[codes[p]];
		assign route_val[p] = route_en[p] && i_periph_out[codes[p]];

		route_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
			route_en[p] |=> (o_pin_periph_en[p] && o_pin_out[p] == $past(i_periph_out[codes[p]])))
			else $error("pin output does not follow selected function");

		zero_release_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
			(codes[p] == `RPS_CODE_NONE) |=> (!o_pin_periph_en[p] && !o_pin_out[p]))
			else $error("pin claimed with no function selected");

		// A pin the port still owns must not see a stray peripheral level
		periph_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
			!o_pin_periph_en[p] |-> !o_pin_out[p])
			else $error("pin driven while not owned");

		pin_steady_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
			($stable(codes[p]) && $stable(i_periph_out)) |=> $stable(o_pin_out[p]))
			else $error("pin output moved with no cause");

		owner_code_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
			o_pin_periph_en[p] |-> ($past(codes[p]) != `RPS_CODE_NONE))
			else $error("pin owned under a zero code");

		pin_source_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
			o_pin_out[p] |-> $past(i_periph_out[codes[p]]))
			else $error("pin high without its source high");

		// Only a clean unlocked write aimed at this slot may touch its code
		slot_guard_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
			!(access_done && i_pwrite && dec.hit && !i_pin_config_lock
				&& dec.slot == pps_pkg::slot_t'(p)) |=> $stable(codes[p]))
			else $error("code changed without a write to its slot");
	end

	always_comb
	begin
		st_d         = st_q;
		st_d.ready   = setup && !st_q.ready;
		st_d.slverr  = setup && !dec.hit;
		st_d.pin_en  = route_en;
		st_d.pin_out = route_val;
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign o_prdata        = {{(`RPS_DATA_W-`RPS_CODE_W){1'b0}}, rd_code};
	assign o_pready        = st_q.ready;
	assign o_pslverr       = st_q.slverr;
	assign o_pin_out       = st_q.pin_out;
	assign o_pin_periph_en = st_q.pin_en;

	upper_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_pready |-> (o_prdata[`RPS_DATA_W-1:`RPS_CODE_W] == '0))
		else $error("unimplemented bits read nonzero");

	lock_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(access_done && i_pwrite && i_pin_config_lock) |=> $stable(codes))
		else $error("code changed while locked");

	write_take_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(access_done && i_pwrite && dec.hit && !i_pin_config_lock)
		|=> (codes[$past(dec.slot)] == $past(i_pwdata[`RPS_CODE_MSB:`RPS_CODE_LSB])))
		else $error("unlocked write not stored");

	reset_zero_a: assert property (@(posedge i_clk_sys)
		$rose(i_reset_n) |-> (codes == '0 && o_prdata == '0))
		else $error("registers not zero after reset");

	map_error_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(setup && !o_pready) |=> (o_pready && (o_pslverr == !$past(dec.hit))))
		else $error("decode answer wrong");

	read_back_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(setup && !o_pready && !i_pwrite && dec.hit)
		|=> (o_prdata[`RPS_CODE_MSB:`RPS_CODE_LSB] == $past(codes[dec.slot])))
		else $error("read data not from addressed register");

	ready_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");

	// The checks below lean on the master holding the address from setup through access
	slverr_pair_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_pslverr |-> o_pready)
		else $error("error flagged without ready");

	slverr_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_pslverr |=> !o_pslverr)
		else $error("error held longer than one cycle");

	miss_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(setup && !i_pwrite && !dec.hit) |=> (o_prdata == '0))
		else $error("unmapped read returned data");

	miss_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(access_done && i_pwrite && !dec.hit) |=> $stable(codes))
		else $error("unmapped write changed a code");

	read_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(access_done && !i_pwrite) |=> $stable(codes))
		else $error("read changed a code");

	idle_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		!(i_psel && i_penable) |=> $stable(codes))
		else $error("code changed outside an access");

	idle_ready_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		!i_psel |=> !o_pready)
		else $error("ready raised while not selected");

	ready_origin_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_pready |-> $past(i_psel && !i_penable))
		else $error("ready without a setup cycle");

	setup_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		setup |-> !o_pready)
		else $error("ready already high in setup");

	// Zero wait states: every access cycle must complete
	access_ready_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_psel && i_penable) |-> o_pready)
		else $error("access cycle stretched");

	hit_clean_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_psel && i_penable && dec.hit) |-> !o_pslverr)
		else $error("mapped access flagged as error");

	miss_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_psel && i_penable && !dec.hit) |-> o_pslverr)
		else $error("unmapped access not flagged");

	misaligned_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(setup && i_paddr[1:0] != 2'h0) |=> o_pslverr)
		else $error("misaligned address accepted");

	high_addr_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(setup && i_paddr[15:14] != 2'h0) |=> o_pslverr)
		else $error("address above window accepted");

	read_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_psel && i_penable && !i_pwrite && dec.hit)
		|-> (o_prdata[`RPS_CODE_MSB:`RPS_CODE_LSB] == codes[dec.slot]))
		else $error("read data differs from stored code");

	prdata_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		!(setup && !i_pwrite) |=> $stable(o_prdata))
		else $error("read data moved between reads");

	// Locked writes stay silent on the bus so old drivers keep running
	locked_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(access_done && i_pwrite && dec.hit && i_pin_config_lock) |-> !o_pslverr)
		else $error("locked write flagged as error");

	locked_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_psel && i_penable && !i_pwrite && dec.hit && i_pin_config_lock) |-> !o_pslverr)
		else $error("read refused while locked");

	locked_pins_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(access_done && i_pwrite && i_pin_config_lock) |=> $stable(o_pin_periph_en))
		else $error("pin ownership moved under lock");

	reset_out_a: assert property (@(posedge i_clk_sys)
		$rose(i_reset_n) |-> (!o_pready && !o_pslverr && o_pin_out == '0
			&& o_pin_periph_en == '0))
		else $error("outputs not quiet after reset");

	release_cov_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		$fell(o_pin_periph_en[0]));

	write_cov_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		access_done && i_pwrite && dec.hit && !i_pin_config_lock);

	locked_cov_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		access_done && i_pwrite && dec.hit && i_pin_config_lock);

	read_cov_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		access_done && !i_pwrite && dec.hit && o_prdata != '0);

	unmapped_cov_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		access_done && o_pslverr);
endmodule

/* File: tb/tb_remappable_pin_output_select.sv */
// Purpose: Self-checking bench for the pin output select register bank
// Assumes: Zero-wait APB slave; pin outputs follow a code change one edge later
// Notes:   Byte address of each register is four times its index
`include "pps_consts.svh"

module tb_remappable_pin_output_select;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk     = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [15:0] paddr   = 16'h0000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic        lock    = 1'b0;
	logic [31:0] periph  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [12:0] pin_out;
	logic [12:0] pin_en;
	int          mismatches  = 0;
	int          check_count = 0;
	logic [11:0] idx [13] = '{`RPS_IDX_PIN3, `RPS_IDX_PIN4, `RPS_IDX_PIN5, `RPS_IDX_PIN6,
		`RPS_IDX_PIN7, `RPS_IDX_PIN8, `RPS_IDX_PIN9, `RPS_IDX_PIN10, `RPS_IDX_PIN11,
		`RPS_IDX_PIN12, `RPS_IDX_PIN13, `RPS_IDX_PIN17, `RPS_IDX_PIN18};

	always #20 clk = ~clk;

	remappable_pin_output_select DUT (
		.i_clk_sys         (clk),
		.i_reset_n         (reset_n),
		.i_psel            (psel),
		.i_penable         (penable),
		.i_pwrite          (pwrite),
		.i_paddr           (paddr),
		.i_pwdata          (pwdata),
		.o_prdata          (prdata),
		.o_pready          (pready),
		.o_pslverr         (pslverr),
		.i_pin_config_lock (lock),
		.i_periph_out      (periph),
		.o_pin_out         (pin_out),
		.o_pin_periph_en   (pin_en)
	);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	// Request held until pready is sampled high; data and error taken at that edge
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [15:0] addr_of(input int k);
		return {2'b00, idx[k], 2'b00};
	endfunction

	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		chk("pin_en", 32'h0, {19'h0, pin_en});
		chk("pin_out", 32'h0, {19'h0, pin_out});
		for (int k = 0; k < 13; k++)
		begin
			apb(1'b0, addr_of(k), 32'h0, r, e);
			chk("reset_value", 32'h0, r);
			chk("slverr", 32'h0, {31'h0, e});
		end
	endtask

	// Ones in bits above the field must not stick
	task automatic t_write_all();
		logic [31:0] r;
		logic        e;
		for (int k = 0; k < 13; k++)
			apb(1'b1, addr_of(k), 32'hFFFF_FFE0 | (k + 1), r, e);
		for (int k = 0; k < 13; k++)
		begin
			apb(1'b0, addr_of(k), 32'h0, r, e);
			chk("code", 32'(k + 1), r);
		end
	endtask

	task automatic t_route();
		logic [31:0] p;
		logic [12:0] exp;
		for (int i = 0; i < 2; i++)
		begin
			p = (i == 0) ? 32'hAAAA_AAAA : 32'h5555_5555;
			periph <= p;
			repeat (3) @(posedge clk);
			for (int k = 0; k < 13; k++)
				exp[k] = p[k + 1];
			chk("pin_out", {19'h0, exp}, {19'h0, pin_out});
			chk("pin_en", 32'h0000_1FFF, {19'h0, pin_en});
		end
	endtask

	task automatic t_zero_lock();
		logic [31:0] r;
		logic        e;
		apb(1'b1, addr_of(0), 32'h0, r, e);
		repeat (3) @(posedge clk);
		chk("pin3_en", 32'h0, {31'h0, pin_en[0]});
		chk("pin3_out", 32'h0, {31'h0, pin_out[0]});
		lock <= 1'b1;
		apb(1'b1, addr_of(1), 32'h1F, r, e);
		chk("locked_err", 32'h0, {31'h0, e});
		apb(1'b0, addr_of(1), 32'h0, r, e);
		chk("locked_code", 32'h2, r);
		lock <= 1'b0;
		apb(1'b1, addr_of(1), 32'h1F, r, e);
		apb(1'b0, addr_of(1), 32'h0, r, e);
		chk("unlocked_code", 32'h1F, r);
	endtask

	// Gap between pin 13 and pin 17, and a misaligned address
	task automatic t_unmapped();
		logic [31:0] r;
		logic        e;
		apb(1'b1, 16'h3B50, 32'h7, r, e);
		chk("wr_slverr", 32'h1, {31'h0, e});
		apb(1'b0, 16'h3B50, 32'h0, r, e);
		chk("rd_slverr", 32'h1, {31'h0, e});
		chk("rd_data", 32'h0, r);
		apb(1'b0, 16'h3B25, 32'h0, r, e);
		chk("misaligned", 32'h1, {31'h0, e});
	endtask

	task automatic conclude();
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_write_all();
		t_route();
		t_zero_lock();
		t_unmapped();
		conclude();
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		conclude();
	end
endmodule
